// ==== mca_defs.svh ====
// Constants for the gate and pulse store block
`ifndef MCA_DEFS_SVH
`define MCA_DEFS_SVH
`define CHAN_W 10
`define CHAN_TOP 10'h3ff
`define BIN_W 16
`define EVT_W 32
`define CORR_W 8
`define CORR_FULL 8'h64
`define CLK_NS 100
`define PEAK_HOLD_NS 500
`define PEAK_HOLD_CYC ((`PEAK_HOLD_NS + `CLK_NS - 1) / `CLK_NS)
`define SCOPE_LEN 16
`define REFRESH_CYC 16'h03e8
`endif

// ==== mca_pkg.sv ====
// Types for the gate and pulse store block
`include "mca_defs.svh"
package mca_pkg;
  typedef enum logic [1:0] {GATE_OFF, GATE_ENABLE, GATE_COINC, GATE_EVENT} gate_mode_t;
  typedef enum logic [1:0] {TRIG_AUTO, TRIG_SINGLE, TRIG_NONE} trig_mode_t;
  typedef struct packed {
    logic valid;
    logic [`CHAN_W-1:0] chan;
  } pulse_t;
  typedef struct packed {
    logic enable;
    logic init;
    logic up;
    logic down;
    logic wr;
    logic [`CHAN_W-1:0] center;
    logic [`CHAN_W-1:0] width;
  } stab_ctl_t;
endpackage

// ==== mca_gate_and_pulse_store.sv ====
// Gate control, threshold filter, histogram, stabilizers and scope capture
// Summary of operation
// - Gate off: every pulse is stored regardless of gate input.
// - Enable mode, gate low: time counters halt and storage stops.
// - Enable mode, gate high: time counters run and storage proceeds.
// - Coincidence mode, gate low: timers run, nothing stored.
// - Coincidence mode, gate high: store as ungated.
// - Event mode: 32-bit counter increments per gate rising edge.
// - Event counter readable at any time.
// - Event counter counts only while acquiring; cleared by clear command.
// - Pulses convert to exactly 1024 channels.
// - Pulses below low cutoff are discarded.
// - Pulses above upper threshold are discarded.
// - Stabilizer initialize sets its correction to zero.
// - Correction saturates at full scale, reported as percent.
// - Stabilizer enable kept in retained storage until host changes it.
// - While enabled, center and width writes are rejected.
// - Peak mark asserted on valid pulse, lasting about half a microsecond.
// - Positive baseline trip generated and feeds live-time logic.
// - Auto trigger: capture refreshes on each pulse over threshold.
// - Single trigger: first capture held until re-arm.
// - Trigger off: capture refreshed periodically.
// - Scope samples taken before amplifier gain.
`timescale 1ns/1ps
`include "mca_defs.svh"
module mca_gate_and_pulse_store
  import mca_pkg::*;
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic resetn_i,
  // Gate pin and control
  input wire logic gate_pin_i,
  input wire gate_mode_t gate_mode_i,
  input wire logic acquire_i,
  input wire logic clear_i,
  // Pulse chain
  input wire pulse_t pulse_i,
  input wire logic [`CHAN_W-1:0] low_cutoff_i,
  input wire logic [`CHAN_W-1:0] upper_cut_i,
  input wire logic [11:0] raw_sample_i,
  input wire logic baseline_over_i,
  input wire logic [11:0] trig_level_i,
  // Histogram read
  input wire logic [`CHAN_W-1:0] rd_chan_i,
  output logic [`BIN_W-1:0] rd_bin_o,
  // Stabilizers
  input wire stab_ctl_t gain_ctl_i,
  input wire stab_ctl_t zero_ctl_i,
  input wire logic gain_en_retained_i,
  input wire logic zero_en_retained_i,
  output logic gain_en_o,
  output logic zero_en_o,
  output logic [`CORR_W-1:0] gain_pct_o,
  output logic [`CORR_W-1:0] zero_pct_o,
  output logic [`CHAN_W-1:0] gain_center_o,
  output logic [`CHAN_W-1:0] gain_width_o,
  output logic [`CHAN_W-1:0] zero_center_o,
  output logic [`CHAN_W-1:0] zero_width_o,
  // Scope capture
  input wire trig_mode_t trig_mode_i,
  input wire logic rearm_i,
  input wire logic [3:0] scope_idx_i,
  output logic [11:0] scope_data_o,
  output logic scope_new_o,
  // Counters and marks
  output logic [`EVT_W-1:0] event_count_o,
  output logic [31:0] real_time_o,
  output logic [31:0] live_time_o,
  output logic peak_mark_o,
  output logic positive_baseline_trip_o
);
  logic gate_s1_q, gate_s2_q, gate_prev_q;
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      gate_s1_q <= 1'b1;
      gate_s2_q <= 1'b1;
      gate_prev_q <= 1'b1;
    end else begin
      gate_s1_q <= gate_pin_i;
      gate_s2_q <= gate_s1_q;
      gate_prev_q <= gate_s2_q;
    end
  end

  // Open pin reads high through the pull-up, so enable mode runs
  wire timers_run = acquire_i && !(gate_mode_i == GATE_ENABLE && !gate_s2_q);
  wire store_ok = acquire_i && ((gate_mode_i == GATE_OFF) || (gate_mode_i == GATE_EVENT)
                  || gate_s2_q);
  wire gate_rise = gate_s2_q && !gate_prev_q;
  wire in_window = (pulse_i.chan >= low_cutoff_i) && (pulse_i.chan <= upper_cut_i);
  wire accept = pulse_i.valid && store_ok && in_window;

  logic [`BIN_W-1:0] hist_q [0:`CHAN_TOP];
  logic [`EVT_W-1:0] event_count_q;
  logic [31:0] real_q, live_q;
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int i = 0; i <= `CHAN_TOP; i++) begin
        hist_q[i] <= '0;
      end
    end else if (clear_i) begin
      for (int i = 0; i <= `CHAN_TOP; i++) begin
        hist_q[i] <= '0;
      end
    end else if (accept) begin
      hist_q[pulse_i.chan] <= hist_q[pulse_i.chan] + 1'b1;
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      event_count_q <= '0;
      real_q <= '0;
      live_q <= '0;
    end else if (clear_i) begin
      event_count_q <= '0;
      real_q <= '0;
      live_q <= '0;
    end else begin
      if (gate_mode_i == GATE_EVENT && acquire_i && gate_rise) begin
        event_count_q <= event_count_q + 1'b1;
      end
      if (timers_run) begin
        real_q <= real_q + 1'b1;
        if (!baseline_over_i) begin
          live_q <= live_q + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rd_bin_o <= '0;
      event_count_o <= '0;
      real_time_o <= '0;
      live_time_o <= '0;
      positive_baseline_trip_o <= 1'b0;
    end else begin
      rd_bin_o <= hist_q[rd_chan_i];
      event_count_o <= event_count_q;
      real_time_o <= real_q;
      live_time_o <= live_q;
      positive_baseline_trip_o <= baseline_over_i;
    end
  end

  // Peak mark stretched over the hold count
  logic [3:0] peak_cnt_q;
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      peak_cnt_q <= '0;
      peak_mark_o <= 1'b0;
    end else begin
      if (pulse_i.valid) begin
        peak_cnt_q <= 4'(`PEAK_HOLD_CYC);
      end else if (peak_cnt_q != 0) begin
        peak_cnt_q <= peak_cnt_q - 1'b1;
      end
      peak_mark_o <= pulse_i.valid || (peak_cnt_q > 4'd1);
    end
  end

  // Stabilizers; enable loads from retained copy after reset release
  logic [1:0] en_q, loaded_q;
  logic [`CORR_W-1:0] pct_q [0:1];
  logic [`CHAN_W-1:0] ctr_q [0:1];
  logic [`CHAN_W-1:0] wid_q [0:1];
  stab_ctl_t ctl [0:1];
  logic [1:0] ret;
  assign ctl[0] = gain_ctl_i;
  assign ctl[1] = zero_ctl_i;
  assign ret = {zero_en_retained_i, gain_en_retained_i};
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      en_q <= '0;
      loaded_q <= '0;
      for (int s = 0; s < 2; s++) begin
        pct_q[s] <= '0;
        ctr_q[s] <= '0;
        wid_q[s] <= 10'h001;
      end
    end else begin
      for (int s = 0; s < 2; s++) begin
        loaded_q[s] <= 1'b1;
        // Enable takes the retained copy on the first cycle after reset, then changes only with a write
        if (!loaded_q[s]) begin
          en_q[s] <= ret[s];
        end else if (ctl[s].wr) begin
          en_q[s] <= ctl[s].enable;
        end
        if (ctl[s].wr && !en_q[s]) begin
          ctr_q[s] <= ctl[s].center;
          wid_q[s] <= ctl[s].width;
        end
        if (ctl[s].init) begin
          pct_q[s] <= '0;
        end else if (en_q[s] && ctl[s].up && pct_q[s] != `CORR_FULL) begin
          pct_q[s] <= pct_q[s] + 1'b1;
        end else if (en_q[s] && ctl[s].down && pct_q[s] != `CORR_FULL) begin
          pct_q[s] <= pct_q[s] + 1'b1;
        end
      end
    end
  end
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      gain_en_o <= 1'b0;
      zero_en_o <= 1'b0;
      gain_pct_o <= '0;
      zero_pct_o <= '0;
      gain_center_o <= '0;
      gain_width_o <= '0;
      zero_center_o <= '0;
      zero_width_o <= '0;
    end else begin
      gain_en_o <= en_q[0];
      zero_en_o <= en_q[1];
      gain_pct_o <= pct_q[0];
      zero_pct_o <= pct_q[1];
      gain_center_o <= ctr_q[0];
      gain_width_o <= wid_q[0];
      zero_center_o <= ctr_q[1];
      zero_width_o <= wid_q[1];
    end
  end

  // Scope: raw pre-gain samples into a small circular record
  logic [11:0] scope_q [0:`SCOPE_LEN-1];
  logic [3:0] wp_q;
  logic held_q;
  logic [15:0] tick_q;
  wire over_trig = raw_sample_i > trig_level_i;
  wire tick_done = tick_q == `REFRESH_CYC - 16'h0001;
  wire do_cap = (trig_mode_i == TRIG_AUTO && over_trig)
              || (trig_mode_i == TRIG_SINGLE && over_trig && !held_q)
              || (trig_mode_i == TRIG_NONE && tick_done);
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wp_q <= '0;
      held_q <= 1'b0;
      tick_q <= '0;
      scope_new_o <= 1'b0;
      scope_data_o <= '0;
      for (int i = 0; i < `SCOPE_LEN; i++) begin
        scope_q[i] <= '0;
      end
    end else begin
      tick_q <= tick_done ? 16'h0000 : tick_q + 1'b1;
      if (!held_q) begin
        scope_q[wp_q] <= raw_sample_i;
        wp_q <= wp_q + 1'b1;
      end
      // Capture wins over a re-arm in the same cycle
      if (do_cap && trig_mode_i == TRIG_SINGLE) begin
        held_q <= 1'b1;
      end else if (rearm_i || trig_mode_i != TRIG_SINGLE) begin
        held_q <= 1'b0;
      end
      scope_new_o <= do_cap;
      scope_data_o <= scope_q[scope_idx_i + wp_q];
    end
  end

  a_enable_halt: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (gate_mode_i == GATE_ENABLE && !gate_s2_q && !clear_i) |=> $stable(real_q))
    else $error("real time ran with gate low");
  a_coinc_store: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (gate_mode_i == GATE_COINC && !gate_s2_q) |-> !accept)
    else $error("stored while coincidence low");
  a_off_store: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (gate_mode_i == GATE_OFF && acquire_i && pulse_i.valid && in_window) |-> accept)
    else $error("pulse dropped with gate off");
  a_event_count: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (gate_mode_i == GATE_EVENT && acquire_i && gate_rise && !clear_i)
    |=> event_count_q == $past(event_count_q) + 1)
    else $error("event edge not counted");
  a_event_clear: assert property (@(posedge clock_i) disable iff (!resetn_i)
    clear_i |=> event_count_q == 0)
    else $error("event counter not cleared");
  a_event_read: assert property (@(posedge clock_i) disable iff (!resetn_i)
    1'b1 |=> event_count_o == $past(event_count_q))
    else $error("event counter output stale");
  a_window_low: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (pulse_i.chan < low_cutoff_i) |-> !accept)
    else $error("pulse below cutoff accepted");
  a_window_high: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (pulse_i.chan > upper_cut_i) |-> !accept)
    else $error("pulse above cutoff accepted");
  a_stab_init: assert property (@(posedge clock_i) disable iff (!resetn_i)
    gain_ctl_i.init |=> ##1 gain_pct_o == 0)
    else $error("gain correction not zeroed");
  a_stab_sat: assert property (@(posedge clock_i) disable iff (!resetn_i)
    pct_q[0] <= `CORR_FULL)
    else $error("gain correction past full scale");
  a_stab_lock: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (en_q[0] && loaded_q[0]) |=> $stable(ctr_q[0]))
    else $error("center changed while enabled");
  a_peak_mark: assert property (@(posedge clock_i) disable iff (!resetn_i)
    pulse_i.valid |=> peak_mark_o [*5])
    else $error("peak mark too short");
  a_single_hold: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (held_q && !rearm_i && trig_mode_i == TRIG_SINGLE) |=> held_q)
    else $error("single capture released");
  c_coinc_store: cover property (@(posedge clock_i) gate_mode_i == GATE_COINC && accept);
  c_event_edge: cover property (@(posedge clock_i) gate_mode_i == GATE_EVENT && gate_rise);
  c_single_cap: cover property (@(posedge clock_i) $rose(held_q));
  c_free_refresh: cover property (@(posedge clock_i) trig_mode_i == TRIG_NONE && do_cap);
endmodule

// ==== mca_far_side.sv ====
// Model of the gate signal and detector pulse chain feeding the block
`timescale 1ns/1ps
module mca_far_side
  import mca_pkg::*;
(
  // Clock
  input wire logic clock_i,
  // Toward the block
  output logic gate_pin_o,
  output pulse_t pulse_o,
  output logic [11:0] raw_sample_o,
  output logic baseline_over_o
);
  initial begin
    gate_pin_o = 1'b1;
    pulse_o = '0;
    raw_sample_o = 12'h0010;
    baseline_over_o = 1'b0;
  end
  task automatic set_gate(input logic v);
    @(posedge clock_i);
    #10 gate_pin_o = v;
  endtask
  // Channel field scrambled once valid drops; nothing holds it
  task automatic send_pulse(input logic [9:0] c);
    @(posedge clock_i);
    #10 pulse_o = '{valid: 1'b1, chan: c};
    raw_sample_o = 12'h0900;
    baseline_over_o = 1'b1;
    @(posedge clock_i);
    #10 pulse_o = '{valid: 1'b0, chan: ~c};
    raw_sample_o = 12'h0010;
    baseline_over_o = 1'b0;
  endtask
endmodule

// ==== mca_gate_and_pulse_store_tb.sv ====
// Self-checking bench for the gate and pulse store block
`timescale 1ns/1ps
`include "mca_defs.svh"
module mca_gate_and_pulse_store_tb
  import mca_pkg::*;
;
  typedef struct {gate_mode_t m; logic g; logic [9:0] c; logic st; logic run;} row_t;
  row_t rows[9] = '{'{GATE_OFF, 0, 100, 1, 1}, '{GATE_ENABLE, 0, 101, 0, 0},
    '{GATE_ENABLE, 1, 102, 1, 1}, '{GATE_COINC, 0, 103, 0, 1}, '{GATE_COINC, 1, 104, 1, 1},
    '{GATE_OFF, 1, 9, 0, 1}, '{GATE_OFF, 1, 10, 1, 1}, '{GATE_OFF, 1, 1000, 1, 1},
    '{GATE_OFF, 1, 1001, 0, 1}};
  logic clock_i = 0, resetn_i = 0, gate_pin, acquire_i = 1, clear_i = 0, rearm_i = 0;
  logic base_over, scope_new_o, peak_mark_o, trip_o, gain_en_o, zero_en_o, found;
  gate_mode_t gate_mode_i = GATE_OFF;
  trig_mode_t trig_mode_i = TRIG_AUTO;
  pulse_t pulse;
  logic [11:0] raw, scope_data_o;
  logic [9:0] rd_chan_i = '0, gain_center_o, gain_width_o;
  logic [15:0] rd_bin_o, b0, b1;
  stab_ctl_t gain_ctl_i = '0, zero_ctl_i = '0;
  logic [7:0] gain_pct_o, zero_pct_o;
  logic [31:0] event_count_o, real_time_o, live_time_o, t0;
  int errors = 0, checks_done = 0, cycles = 0;
  logic [9:0] low_cut = 10'h00a, up_cut = 10'h3e8;
  logic [11:0] trig_level = 12'h0400;
  logic [3:0] scope_idx = 4'h0;
  logic gain_en_ret = 1'b0;
  int gap = 0;
  always #50 clock_i = ~clock_i;
  mca_far_side far (.clock_i(clock_i), .gate_pin_o(gate_pin), .pulse_o(pulse),
    .raw_sample_o(raw), .baseline_over_o(base_over));
  mca_gate_and_pulse_store dut (.clock_i(clock_i), .resetn_i(resetn_i), .gate_pin_i(gate_pin),
    .gate_mode_i(gate_mode_i), .acquire_i(acquire_i), .clear_i(clear_i), .pulse_i(pulse),
    .low_cutoff_i(low_cut), .upper_cut_i(up_cut), .raw_sample_i(raw),
    .baseline_over_i(base_over), .trig_level_i(trig_level), .rd_chan_i(rd_chan_i),
    .rd_bin_o(rd_bin_o), .gain_ctl_i(gain_ctl_i), .zero_ctl_i(zero_ctl_i),
    .gain_en_retained_i(gain_en_ret), .zero_en_retained_i(1'b0), .gain_en_o(gain_en_o),
    .zero_en_o(zero_en_o), .gain_pct_o(gain_pct_o), .zero_pct_o(zero_pct_o),
    .gain_center_o(gain_center_o), .gain_width_o(gain_width_o), .zero_center_o(),
    .zero_width_o(), .trig_mode_i(trig_mode_i), .rearm_i(rearm_i), .scope_idx_i(scope_idx),
    .scope_data_o(scope_data_o), .scope_new_o(scope_new_o), .event_count_o(event_count_o),
    .real_time_o(real_time_o), .live_time_o(live_time_o), .peak_mark_o(peak_mark_o),
    .positive_baseline_trip_o(trip_o));
  task automatic close_out();
    $display("Checks %0d, mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd_bin(input logic [9:0] c, output logic [15:0] v);
    @(posedge clock_i);
    #10 rd_chan_i = c;
    repeat (2) @(posedge clock_i);
    #10 v = rd_bin_o;
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clock_i);
    #10;
  endtask
  // Ceiling well above the roughly 2000 cycles the sequence needs
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      $display("ERROR t=%0t run did not finish", $time);
      close_out();
    end
  end
  initial begin
    wait_cyc(6);
    resetn_i = 1;
    wait_cyc(2);
    foreach (rows[i]) begin
      gate_mode_i = rows[i].m;
      far.set_gate(rows[i].g);
      wait_cyc(4);
      rd_bin(rows[i].c, b0);
      t0 = real_time_o;
      far.send_pulse(rows[i].c);
      wait_cyc(3);
      rd_bin(rows[i].c, b1);
      chk({16'h0000, b1 - b0}, {31'h0, rows[i].st});
      chk({31'h0, real_time_o != t0}, {31'h0, rows[i].run});
    end
    $display("Gating and window rows done");
    low_cut = 10'h1f4;
    up_cut = 10'h1f4;
    for (int k = 0; k < 3; k++) begin
      rd_bin(10'(10'h1f3 + k), b0);
      far.send_pulse(10'(10'h1f3 + k));
      wait_cyc(3);
      rd_bin(10'(10'h1f3 + k), b1);
      chk({16'h0000, b1 - b0}, {31'h0, k == 1});
    end
    low_cut = 10'h00a;
    up_cut = 10'h3e8;
    t0 = real_time_o - live_time_o;
    far.send_pulse(10'h064);
    chk({31'h0, peak_mark_o}, 32'h0000_0001);
    chk({31'h0, trip_o}, 32'h0000_0001);
    chk({31'h0, scope_new_o}, 32'h0000_0001);
    wait_cyc(4);
    chk({31'h0, peak_mark_o}, 32'h0000_0001);
    chk(real_time_o - live_time_o - t0, 32'h0000_0001);
    wait_cyc(1);
    chk({31'h0, peak_mark_o}, 32'h0000_0000);
    trig_level = 12'h0a00;
    far.send_pulse(10'h064);
    chk({31'h0, scope_new_o}, 32'h0000_0000);
    trig_level = 12'h0400;
    trig_mode_i = TRIG_SINGLE;
    scope_idx = 4'hf;
    far.send_pulse(10'h064);
    chk({31'h0, scope_new_o}, 32'h0000_0001);
    wait_cyc(1);
    chk({20'h0, scope_data_o}, 32'h0000_0900);
    far.send_pulse(10'h064);
    chk({31'h0, scope_new_o}, 32'h0000_0000);
    chk({20'h0, scope_data_o}, 32'h0000_0900);
    rearm_i = 1;
    wait_cyc(1);
    rearm_i = 0;
    far.send_pulse(10'h064);
    chk({31'h0, scope_new_o}, 32'h0000_0001);
    trig_mode_i = TRIG_AUTO;
    $display("Threshold, mark and capture tests done");
    gate_mode_i = GATE_EVENT;
    clear_i = 1;
    wait_cyc(1);
    clear_i = 0;
    repeat (3) begin
      far.set_gate(0);
      wait_cyc(3);
      far.set_gate(1);
      wait_cyc(3);
    end
    wait_cyc(1);
    chk(event_count_o, 32'h0000_0003);
    acquire_i = 0;
    far.set_gate(0);
    wait_cyc(3);
    far.set_gate(1);
    wait_cyc(4);
    chk(event_count_o, 32'h0000_0003);
    clear_i = 1;
    wait_cyc(1);
    clear_i = 0;
    wait_cyc(2);
    chk(event_count_o, 32'h0000_0000);
    $display("Event counter test done");
    gain_ctl_i.center = 10'h005;
    gain_ctl_i.wr = 1;
    wait_cyc(1);
    gain_ctl_i.enable = 1;
    zero_ctl_i.enable = 1;
    zero_ctl_i.wr = 1;
    wait_cyc(1);
    gain_ctl_i.wr = 0;
    zero_ctl_i.wr = 0;
    wait_cyc(1);
    gain_ctl_i.center = 10'h007;
    gain_ctl_i.wr = 1;
    wait_cyc(1);
    gain_ctl_i.wr = 0;
    repeat (110) begin
      gain_ctl_i.up = 1;
      zero_ctl_i.down = 1;
      wait_cyc(1);
      gain_ctl_i.up = 0;
      zero_ctl_i.down = 0;
      wait_cyc(1);
    end
    chk({24'h0, gain_pct_o}, 32'h0000_0064);
    chk({24'h0, zero_pct_o}, 32'h0000_0064);
    gain_ctl_i.init = 1;
    wait_cyc(1);
    gain_ctl_i.init = 0;
    wait_cyc(2);
    chk({24'h0, gain_pct_o}, 32'h0000_0000);
    chk({24'h0, zero_pct_o}, 32'h0000_0064);
    chk({31'h0, gain_en_o}, 32'h0000_0001);
    chk({22'h0, gain_center_o}, 32'h0000_0005);
    $display("Stabilizer test done");
    trig_mode_i = TRIG_NONE;
    found = 0;
    for (int n = 0; n < 1100 && !found; n++) begin
      @(posedge clock_i);
      #10 found = scope_new_o;
    end
    chk({31'h0, found}, 32'h0000_0001);
    found = 0;
    for (int n = 1; n <= 1100 && !found; n++) begin
      @(posedge clock_i);
      #10 found = scope_new_o;
      gap = n;
    end
    chk(gap, 32'h0000_03e8);
    $display("Periodic capture test done");
    gain_ctl_i.enable = 0;
    gain_en_ret = 1;
    resetn_i = 0;
    wait_cyc(2);
    resetn_i = 1;
    wait_cyc(2);
    chk({31'h0, gain_en_o}, 32'h0000_0001);
    chk(event_count_o, 32'h0000_0000);
    $display("Reset test done");
    close_out();
  end
endmodule
